// *** core/nfcirq_pkg.sv ***
// Package: register map, field positions and carrier types of the interrupt flag block
package nfcirq_pkg;

    localparam int unsigned AW = 8;
    localparam int unsigned DW = 8;
    localparam int unsigned FW = 10;

    // Register offsets
    localparam logic [AW-1:0] ADDR_MASK_MAIN  = 8'h16;
    localparam logic [AW-1:0] ADDR_MASK_TF    = 8'h17;
    localparam logic [AW-1:0] ADDR_MASK_ERRWU = 8'h18;
    localparam logic [AW-1:0] ADDR_MASK_TGT   = 8'h19;
    localparam logic [AW-1:0] ADDR_FLAGS_MAIN = 8'h1A;
    localparam logic [AW-1:0] ADDR_FLAGS_TF   = 8'h1B;
    localparam logic [AW-1:0] ADDR_HK_STATUS  = 8'h20;
    localparam logic [AW-1:0] ADDR_HK_CLEAR   = 8'h21;
    localparam logic [AW-1:0] ADDR_HK_ENABLE  = 8'h22;

    // Reset values and implemented bits
    localparam logic [DW-1:0] MASK_RESET  = 8'h00;
    localparam logic [DW-1:0] FLAG_RESET  = 8'h00;
    localparam logic [DW-1:0] HK_RESET    = 8'h00;
    localparam logic [DW-1:0] MAIN_VALID  = 8'hFE;
    localparam logic [DW-1:0] TF_VALID    = 8'hFF;
    localparam logic [DW-1:0] TGT_VALID   = 8'h7B;
    localparam logic [DW-1:0] HK_VALID    = 8'h07;

    // Main flag and mask bit positions
    localparam int unsigned MAIN_OSC      = 7;
    localparam int unsigned MAIN_FIFO_LVL = 6;
    localparam int unsigned MAIN_RX_START = 5;
    localparam int unsigned MAIN_RX_END   = 4;
    localparam int unsigned MAIN_TX_END   = 3;
    localparam int unsigned MAIN_BIT_COL  = 2;
    localparam int unsigned MAIN_RX_RST   = 1;

    // Timer and field flag and mask bit positions
    localparam int unsigned TF_CMD_DONE   = 7;
    localparam int unsigned TF_NRT        = 6;
    localparam int unsigned TF_GPT        = 5;
    localparam int unsigned TF_FIELD_ON   = 4;
    localparam int unsigned TF_FIELD_OFF  = 3;
    localparam int unsigned TF_CA_COL     = 2;
    localparam int unsigned TF_GUARD      = 1;
    localparam int unsigned TF_BITRATE    = 0;

    // Housekeeping status bit positions
    localparam int unsigned HK_MAIN_LOST  = 0;
    localparam int unsigned HK_TF_LOST    = 1;
    localparam int unsigned HK_BAD_ADDR   = 2;

    // FIFO water levels in bytes
    localparam logic [FW-1:0] FIFO_RX_LEVEL = 10'h12C;
    localparam logic [FW-1:0] FIFO_TX_LEVEL = 10'h0C8;

    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic          wr;
        logic          rd;
    } nfcirq_reg_req_t;

    typedef struct packed {
        logic rx_start;
        logic rx_end;
        logic tx_end;
        logic bit_collision;
        logic rx_restart;
    } nfcirq_main_ev_t;

    typedef struct packed {
        logic cmd_done;
        logic nrt_expire;
        logic gpt_expire;
        logic ca_collision;
        logic guard_elapsed;
        logic bitrate_found;
    } nfcirq_tf_ev_t;

    typedef struct packed {
        logic rx_active;
        logic tx_active;
        logic osc_en;
        logic ca_no_ext_field;
        logic own_field_on;
        logic target_mode;
    } nfcirq_ctx_t;

endpackage

// *** core/nfcirq_flag_reg.sv ***
// Sticky flag register with clear on read, set wins over clear
`timescale 1ns/1ps
`default_nettype none
module nfcirq_flag_reg #(
    parameter int unsigned     W     = 8,
    parameter logic [W-1:0]    VALID = '1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] set,
    input  wire logic         clr,
    output var  logic [W-1:0] flags,
    output var  logic         lost
);

    logic [W-1:0] flags_q;
    logic [W-1:0] flags_d;

    always_comb begin
        flags_d = ((clr ? '0 : flags_q) | set) & VALID;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_d;
        end
    end

    assign flags = flags_q;
    assign lost  = |(set & flags_q & VALID);

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_set_wins_clear: assert property ( // RL16
        (|(set & VALID)) |=> ((flags & $past(set & VALID)) == $past(set & VALID)))
        else $error("Flag event lost");

    a_read_clears_all: assert property ( // RL17
        (clr && !(|set)) |=> (flags == '0))
        else $error("Flags not cleared after read");

endmodule
`default_nettype wire

// *** core/nfcirq_top.sv ***
// Interrupt flags, masks and request output of the transceiver control logic
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RL1: Mask bit one suppresses its event's request; masks reset to zero.
// RL2: Main mask: osc 7, FIFO 6, rx start 5, rx end 4, tx end 3, collision 2, restart 1.
// RL3: Timer/field mask: cmd 7, nrt 6, gpt 5, field on 4, off 3, avoid 2, guard 1, rate 0.
// RL4: Error/wake-up mask: CRC 7, parity 6, soft 5, hard 4, timer 3, amp 2, phase 1, cap 0.
// RL5: Target mask: slot 6, field on 5, auto rx 4, high rate 3, star 1, active 0.
// RL6: Oscillator flag bit 7 set when enabled oscillator settles.
// RL7: While receiving, FIFO level flag set above 300 bytes.
// RL8: While transmitting, FIFO level flag set below 200 bytes.
// RL9: Main flags report rx start, rx end, tx end, collision; read only.
// RL10: Restart flag bit 1 set when a disturbed frame restarts reception.
// RL11: Timer/field flags: command done 7, no-response 6, general timer 5.
// RL12: Field rising above activation sets bit 4, falling sets bit 3.
// RL13: Host clears avoidance flag before avoidance; device sets it on collision.
// RL14: Guard flag bit 1 set after guard time when own field switched on.
// RL15: Bit-rate flag bit 0 set when target mode recognises initiator rate.
// RL16: Reading timer/field flags returns them, then clears all bits; a flag whose event arrives in the read cycle stays set.
// RL17: Reading main flags returns them, then clears all bits; a flag whose event arrives in the read cycle stays set.
// RL18: Interrupt output high while any flag is pending with mask clear.
module nfcirq_top (
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire nfcirq_pkg::nfcirq_reg_req_t  reg_req,
    output var  logic [nfcirq_pkg::DW-1:0]    reg_rdata,
    input  wire nfcirq_pkg::nfcirq_main_ev_t  main_ev,
    input  wire nfcirq_pkg::nfcirq_tf_ev_t    tf_ev,
    input  wire nfcirq_pkg::nfcirq_ctx_t      ctx,
    input  wire logic [nfcirq_pkg::FW-1:0]    fifo_count,
    input  wire logic                         osc_stable_pin,
    input  wire logic                         ext_field_pin,
    input  wire logic [nfcirq_pkg::DW-1:0]    errwu_pending,
    input  wire logic [nfcirq_pkg::DW-1:0]    tgt_pending,
    output var  logic                         irq
);

    logic [nfcirq_pkg::DW-1:0] mask_main_q;
    logic [nfcirq_pkg::DW-1:0] mask_tf_q;
    logic [nfcirq_pkg::DW-1:0] mask_errwu_q;
    logic [nfcirq_pkg::DW-1:0] mask_tgt_q;
    logic [nfcirq_pkg::DW-1:0] hk_status_q;
    logic [nfcirq_pkg::DW-1:0] hk_enable_q;
    logic [nfcirq_pkg::DW-1:0] hk_set;
    logic [nfcirq_pkg::DW-1:0] rdata_q;
    logic [nfcirq_pkg::DW-1:0] rdata_d;
    logic [nfcirq_pkg::DW-1:0] main_set;
    logic [nfcirq_pkg::DW-1:0] tf_set;
    logic [nfcirq_pkg::DW-1:0] main_flags;
    logic [nfcirq_pkg::DW-1:0] tf_flags;
    logic                      main_lost;
    logic                      tf_lost;
    logic [1:0]                sync1_q;
    logic [1:0]                sync2_q;
    logic [1:0]                sync3_q;
    logic                      osc_rise;
    logic                      field_rise;
    logic                      field_fall;
    logic                      fifo_cond;
    logic                      fifo_cond_q;
    logic                      rd_main;
    logic                      rd_tf;
    logic                      addr_known;
    logic                      wr_mask_main;
    logic                      wr_mask_tf;
    logic                      wr_mask_errwu;
    logic                      wr_mask_tgt;
    logic                      wr_hk_clear;
    logic                      wr_hk_enable;

    // Address decode
    always_comb begin
        wr_mask_main  = 1'b0;
        wr_mask_tf    = 1'b0;
        wr_mask_errwu = 1'b0;
        wr_mask_tgt   = 1'b0;
        wr_hk_clear   = 1'b0;
        wr_hk_enable  = 1'b0;
        rd_main       = 1'b0;
        rd_tf         = 1'b0;
        addr_known    = 1'b1;
        if (reg_req.addr == nfcirq_pkg::ADDR_MASK_MAIN) begin
            wr_mask_main = reg_req.wr;
        end else if (reg_req.addr == nfcirq_pkg::ADDR_MASK_TF) begin
            wr_mask_tf = reg_req.wr;
        end else if (reg_req.addr == nfcirq_pkg::ADDR_MASK_ERRWU) begin
            wr_mask_errwu = reg_req.wr;
        end else if (reg_req.addr == nfcirq_pkg::ADDR_MASK_TGT) begin
            wr_mask_tgt = reg_req.wr;
        end else if (reg_req.addr == nfcirq_pkg::ADDR_FLAGS_MAIN) begin
            rd_main = reg_req.rd;
        end else if (reg_req.addr == nfcirq_pkg::ADDR_FLAGS_TF) begin
            rd_tf = reg_req.rd;
        end else if (reg_req.addr == nfcirq_pkg::ADDR_HK_STATUS) begin
            addr_known = 1'b1;
        end else if (reg_req.addr == nfcirq_pkg::ADDR_HK_CLEAR) begin
            wr_hk_clear = reg_req.wr;
        end else if (reg_req.addr == nfcirq_pkg::ADDR_HK_ENABLE) begin
            wr_hk_enable = reg_req.wr;
        end else begin
            addr_known = 1'b0;
        end
    end

    // RL1: mask storage, reset zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mask_main_q  <= nfcirq_pkg::MASK_RESET;
            mask_tf_q    <= nfcirq_pkg::MASK_RESET;
            mask_errwu_q <= nfcirq_pkg::MASK_RESET;
            mask_tgt_q   <= nfcirq_pkg::MASK_RESET;
        end else begin
            // RL2: main mask bit 0 unused
            if (wr_mask_main) begin
                mask_main_q <= reg_req.wdata & nfcirq_pkg::MAIN_VALID;
            end
            // RL3: timer/field mask all bits
            if (wr_mask_tf) begin
                mask_tf_q <= reg_req.wdata & nfcirq_pkg::TF_VALID;
            end
            // RL4: error/wake-up mask all bits
            if (wr_mask_errwu) begin
                mask_errwu_q <= reg_req.wdata;
            end
            // RL5: target mask reserved bits
            if (wr_mask_tgt) begin
                mask_tgt_q <= reg_req.wdata & nfcirq_pkg::TGT_VALID;
            end
        end
    end

    // Pin synchronisers: bit 0 oscillator, bit 1 field
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_q <= 2'h0;
            sync2_q <= 2'h0;
            sync3_q <= 2'h0;
        end else begin
            sync1_q <= {ext_field_pin, osc_stable_pin};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    assign osc_rise   = sync2_q[0] & ~sync3_q[0];
    assign field_rise = sync2_q[1] & ~sync3_q[1];
    assign field_fall = ~sync2_q[1] & sync3_q[1];

    // RL7: receive water level
    // RL8: transmit water level
    always_comb begin
        fifo_cond = (ctx.rx_active && (fifo_count > nfcirq_pkg::FIFO_RX_LEVEL))
                 || (ctx.tx_active && (fifo_count < nfcirq_pkg::FIFO_TX_LEVEL));
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fifo_cond_q <= 1'b0;
        end else begin
            fifo_cond_q <= fifo_cond;
        end
    end

    // Main flag sources
    always_comb begin
        main_set = nfcirq_pkg::FLAG_RESET;
        // RL6: oscillator settled
        main_set[nfcirq_pkg::MAIN_OSC]      = osc_rise & ctx.osc_en;
        main_set[nfcirq_pkg::MAIN_FIFO_LVL] = fifo_cond & ~fifo_cond_q;
        // RL9: receive, transmit, collision
        main_set[nfcirq_pkg::MAIN_RX_START] = main_ev.rx_start;
        main_set[nfcirq_pkg::MAIN_RX_END]   = main_ev.rx_end;
        main_set[nfcirq_pkg::MAIN_TX_END]   = main_ev.tx_end;
        main_set[nfcirq_pkg::MAIN_BIT_COL]  = main_ev.bit_collision;
        // RL10: disturbed frame restart
        main_set[nfcirq_pkg::MAIN_RX_RST]   = main_ev.rx_restart;
    end

    // Timer and field flag sources
    always_comb begin
        tf_set = nfcirq_pkg::FLAG_RESET;
        // RL11: command and timers
        tf_set[nfcirq_pkg::TF_CMD_DONE]  = tf_ev.cmd_done;
        tf_set[nfcirq_pkg::TF_NRT]       = tf_ev.nrt_expire;
        tf_set[nfcirq_pkg::TF_GPT]       = tf_ev.gpt_expire;
        // RL12: external field edges
        tf_set[nfcirq_pkg::TF_FIELD_ON]  = field_rise;
        tf_set[nfcirq_pkg::TF_FIELD_OFF] = field_fall;
        // RL13: avoidance collision
        tf_set[nfcirq_pkg::TF_CA_COL]    = tf_ev.ca_collision;
        // RL14: guard time elapsed
        tf_set[nfcirq_pkg::TF_GUARD]     = tf_ev.guard_elapsed & ctx.ca_no_ext_field
                                         & ctx.own_field_on;
        // RL15: bit rate recognised
        tf_set[nfcirq_pkg::TF_BITRATE]   = tf_ev.bitrate_found & ctx.target_mode;
    end

    // RL17: main flags clear on read
    nfcirq_flag_reg #(
        .W     (nfcirq_pkg::DW),
        .VALID (nfcirq_pkg::MAIN_VALID)
    ) u_main_flags (
        .clk   (clk),
        .rst   (rst),
        .set   (main_set),
        .clr   (rd_main),
        .flags (main_flags),
        .lost  (main_lost)
    );

    // RL16: timer/field flags clear on read
    nfcirq_flag_reg #(
        .W     (nfcirq_pkg::DW),
        .VALID (nfcirq_pkg::TF_VALID)
    ) u_tf_flags (
        .clk   (clk),
        .rst   (rst),
        .set   (tf_set),
        .clr   (rd_tf),
        .flags (tf_flags),
        .lost  (tf_lost)
    );

    // Housekeeping events
    always_comb begin
        hk_set = nfcirq_pkg::HK_RESET;
        hk_set[nfcirq_pkg::HK_MAIN_LOST] = main_lost;
        hk_set[nfcirq_pkg::HK_TF_LOST]   = tf_lost;
        hk_set[nfcirq_pkg::HK_BAD_ADDR]  = (reg_req.wr | reg_req.rd) & ~addr_known;
    end

    // Sticky status, set wins over write clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hk_status_q <= nfcirq_pkg::HK_RESET;
        end else if (wr_hk_clear) begin
            hk_status_q <= ((hk_status_q & ~reg_req.wdata) | hk_set) & nfcirq_pkg::HK_VALID;
        end else begin
            hk_status_q <= (hk_status_q | hk_set) & nfcirq_pkg::HK_VALID;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hk_enable_q <= nfcirq_pkg::HK_RESET;
        end else if (wr_hk_enable) begin
            hk_enable_q <= reg_req.wdata & nfcirq_pkg::HK_VALID;
        end
    end

    // Read mux, data valid one cycle after strobe
    always_comb begin
        rdata_d = '0;
        if (reg_req.rd) begin
            if (reg_req.addr == nfcirq_pkg::ADDR_MASK_MAIN) begin
                rdata_d = mask_main_q;
            end else if (reg_req.addr == nfcirq_pkg::ADDR_MASK_TF) begin
                rdata_d = mask_tf_q;
            end else if (reg_req.addr == nfcirq_pkg::ADDR_MASK_ERRWU) begin
                rdata_d = mask_errwu_q;
            end else if (reg_req.addr == nfcirq_pkg::ADDR_MASK_TGT) begin
                rdata_d = mask_tgt_q;
            end else if (reg_req.addr == nfcirq_pkg::ADDR_FLAGS_MAIN) begin
                rdata_d = main_flags;
            end else if (reg_req.addr == nfcirq_pkg::ADDR_FLAGS_TF) begin
                rdata_d = tf_flags;
            end else if (reg_req.addr == nfcirq_pkg::ADDR_HK_STATUS) begin
                rdata_d = hk_status_q;
            end else if (reg_req.addr == nfcirq_pkg::ADDR_HK_ENABLE) begin
                rdata_d = hk_enable_q;
            end else begin
                rdata_d = '0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // RL18: unmasked pending request
    always_comb begin
        irq = |(main_flags & ~mask_main_q)
           || |(tf_flags & ~mask_tf_q)
           || |(errwu_pending & ~mask_errwu_q)
           || |(tgt_pending & ~mask_tgt_q & nfcirq_pkg::TGT_VALID)
           || |(hk_status_q & hk_enable_q);
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_irq_unmasked_flag: assert property ( // RL18
        (|(main_flags & ~mask_main_q) || |(tf_flags & ~mask_tf_q)) |-> irq)
        else $error("Unmasked flag without interrupt");

    a_irq_fully_masked: assert property ( // RL1
        ((mask_main_q == nfcirq_pkg::MAIN_VALID) && (mask_tf_q == 8'hFF)
         && (mask_errwu_q == 8'hFF) && (mask_tgt_q == nfcirq_pkg::TGT_VALID)
         && (hk_enable_q == 8'h00)) |-> !irq)
        else $error("Interrupt while all sources masked");

    a_mask_write_read: assert property ( // RL2
        (reg_req.wr && reg_req.addr == nfcirq_pkg::ADDR_MASK_MAIN)
        ##1 (reg_req.rd && reg_req.addr == nfcirq_pkg::ADDR_MASK_MAIN)
        |=> (reg_rdata == ($past(reg_req.wdata, 2) & 8'hFE)))
        else $error("Main mask readback wrong");

    a_main_read_value: assert property ( // RL9
        (reg_req.rd && reg_req.addr == nfcirq_pkg::ADDR_FLAGS_MAIN)
        |=> (reg_rdata == $past(main_flags)))
        else $error("Main flag read value wrong");

    a_tf_read_clear: assert property ( // RL16
        (reg_req.rd && reg_req.addr == nfcirq_pkg::ADDR_FLAGS_TF && !(|tf_set))
        |=> (tf_flags == 8'h00) && (reg_rdata == $past(tf_flags)))
        else $error("Timer/field read did not clear");

    a_fifo_rx_level: assert property ( // RL7
        (ctx.rx_active && !ctx.tx_active && fifo_count == 10'h12D && !fifo_cond_q)
        |=> main_flags[6])
        else $error("Receive water level flag missing");

    a_fifo_tx_level: assert property ( // RL8
        (ctx.tx_active && !ctx.rx_active && fifo_count == 10'h0C7 && !fifo_cond_q)
        |=> main_flags[6])
        else $error("Transmit water level flag missing");

    a_field_rise_flag: assert property ( // RL12
        (sync2_q[1] && !sync3_q[1]) |=> tf_flags[4])
        else $error("Field rise flag missing");

    a_osc_stable_flag: assert property ( // RL6
        ($rose(sync2_q[0]) && ctx.osc_en) |=> main_flags[7])
        else $error("Oscillator flag missing");

    a_guard_needs_field: assert property ( // RL14
        (tf_ev.guard_elapsed && !ctx.own_field_on && !tf_flags[1]) |=> !tf_flags[1])
        else $error("Guard flag set without own field");

    a_bad_addr_sticky: assert property (
        (reg_req.rd && !addr_known) |=> hk_status_q[2] [*2])
        else $error("Unmapped access not recorded");

    c_main_read_nonzero: cover property (
        (reg_req.rd && reg_req.addr == nfcirq_pkg::ADDR_FLAGS_MAIN && main_flags != 8'h00));
    c_irq_rise: cover property ($rose(irq));
    c_event_during_read: cover property (rd_tf && (|tf_set));
    c_main_lost: cover property (main_lost);

endmodule
`default_nettype wire

// *** bench/nfcirq_host.sv ***
// Host model: register writes and reads toward the interrupt block
`timescale 1ns/1ps
`default_nettype none
module nfcirq_host (
    input  wire logic                       clk,
    output var  nfcirq_pkg::nfcirq_reg_req_t reg_req,
    input  wire logic [nfcirq_pkg::DW-1:0]  reg_rdata
);
    initial reg_req = '0;

    // One-cycle write strobe, then address and data scrambled
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        reg_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask

    // One-cycle read strobe, data taken in the following cycle
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        reg_req <= '{addr: ~a, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
        #1;
        d = reg_rdata;
    endtask

    // Write strobe followed at once by a read strobe, data taken after the read
    task automatic wrrd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        reg_req <= '{addr: ~a, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
        #1;
        q = reg_rdata;
    endtask

    task automatic prep_avoid();
        logic [7:0] d;
        rd(nfcirq_pkg::ADDR_FLAGS_TF, d);
    endtask
endmodule
`default_nettype wire

// *** bench/nfc_irq_flags_and_masks_tb.sv ***
// Self-checking bench of the interrupt flag and mask block
`timescale 1ns/1ps
`default_nettype none
module nfc_irq_flags_and_masks_tb;
    logic                        clk = 1'b0;
    logic                        rst = 1'b1;
    nfcirq_pkg::nfcirq_reg_req_t req;
    logic [7:0]                  rdata;
    nfcirq_pkg::nfcirq_main_ev_t mev = '0;
    nfcirq_pkg::nfcirq_tf_ev_t   tev = '0;
    nfcirq_pkg::nfcirq_ctx_t     ctx = '0;
    logic [9:0]                  fcnt = 10'h000;
    logic                        osc_p = 1'b0;
    logic                        fld_p = 1'b0;
    logic [7:0]                  ewp = 8'h00;
    logic [7:0]                  tgp = 8'h00;
    logic                        irq;
    logic [31:0]                 seed = 32'h0000_6dd8;
    logic [7:0]                  mm;
    logic [7:0]                  mt;
    logic [7:0]                  vld [4] = '{8'hFE, 8'hFF, 8'hFF, 8'h7B};
    int                          failures = 0;
    int                          checks = 0;
    int                          cyc = 0;

    always #20 clk = ~clk;

    nfcirq_host host (.clk(clk), .reg_req(req), .reg_rdata(rdata));

    nfcirq_top dut (
        .clk            (clk),
        .rst            (rst),
        .reg_req        (req),
        .reg_rdata      (rdata),
        .main_ev        (mev),
        .tf_ev          (tev),
        .ctx            (ctx),
        .fifo_count     (fcnt),
        .osc_stable_pin (osc_p),
        .ext_field_pin  (fld_p),
        .errwu_pending  (ewp),
        .tgt_pending    (tgp),
        .irq            (irq)
    );

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [7:0] mainb(input nfcirq_pkg::nfcirq_main_ev_t m);
        return {2'b00, m, 1'b0};
    endfunction

    function automatic logic [7:0] tfb(input nfcirq_pkg::nfcirq_tf_ev_t t);
        return {t[5:3], 2'b00, t[2:0]};
    endfunction

    task automatic results();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        host.rd(a, v);
        chk(v, exp);
    endtask

    task automatic pulse(input logic [4:0] m, input logic [5:0] t);
        @(posedge clk);
        mev <= m;
        tev <= t;
        @(posedge clk);
        mev <= '0;
        tev <= '0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic lvl(input logic [5:0] c, input logic [9:0] n, input logic [7:0] exp);
        @(posedge clk);
        ctx <= c;
        fcnt <= n;
        repeat (3) @(posedge clk);
        rdchk(nfcirq_pkg::ADDR_FLAGS_MAIN, exp);
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            results();
        end
    end

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 4; a++) begin
            rdchk(8'h16 + 8'(a), 8'h00);
            host.wrrd(8'h16 + 8'(a), 8'hFF, mm);
            chk(mm, vld[a]);
        end
        // Random pending inputs against random masks
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            host.wr(nfcirq_pkg::ADDR_MASK_ERRWU, seed[23:16]);
            host.wr(nfcirq_pkg::ADDR_MASK_TGT, seed[31:24]);
            @(posedge clk);
            ewp <= seed[7:0];
            tgp <= seed[15:8] & nfcirq_pkg::TGT_VALID;
            repeat (2) @(posedge clk);
            #1;
            chk(8'(irq), 8'(|(ewp & ~seed[23:16]) | |(tgp & ~seed[31:24])));
        end
        @(posedge clk);
        ewp <= 8'h00;
        tgp <= 8'h00;
        ctx <= 6'h07;
        // Random event pulses, first all sources open, then all masked, then random masks
        for (int i = 0; i < 12; i++) begin
            seed = xs(seed);
            mm = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : seed[18:11];
            mt = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : seed[26:19];
            if (i == 0)
                seed[10:0] = 11'h7FF;
            host.wr(nfcirq_pkg::ADDR_MASK_MAIN, mm);
            host.wr(nfcirq_pkg::ADDR_MASK_TF, mt);
            host.prep_avoid();
            pulse(seed[4:0], seed[10:5]);
            chk(8'(irq), 8'(|(mainb(seed[4:0]) & ~mm & 8'hFE) | |(tfb(seed[10:5]) & ~mt)));
            rdchk(nfcirq_pkg::ADDR_FLAGS_MAIN, mainb(seed[4:0]));
            rdchk(nfcirq_pkg::ADDR_FLAGS_TF, tfb(seed[10:5]));
            rdchk(nfcirq_pkg::ADDR_FLAGS_MAIN, 8'h00);
            rdchk(nfcirq_pkg::ADDR_FLAGS_TF, 8'h00);
            chk(8'(irq), 8'h00);
        end
        @(posedge clk);
        ctx <= 6'h00;
        pulse(5'h00, 6'h03);
        rdchk(nfcirq_pkg::ADDR_FLAGS_TF, 8'h00);
        @(posedge clk);
        ctx <= 6'h08;
        osc_p <= 1'b1;
        fld_p <= 1'b1;
        repeat (6) @(posedge clk);
        rdchk(nfcirq_pkg::ADDR_FLAGS_MAIN, 8'h80);
        rdchk(nfcirq_pkg::ADDR_FLAGS_TF, 8'h10);
        @(posedge clk);
        fld_p <= 1'b0;
        repeat (6) @(posedge clk);
        rdchk(nfcirq_pkg::ADDR_FLAGS_TF, 8'h08);
        lvl(6'h20, 10'h12C, 8'h00);
        lvl(6'h20, 10'h12D, 8'h40);
        lvl(6'h10, 10'h0C8, 8'h00);
        lvl(6'h10, 10'h0C7, 8'h40);
        host.wr(nfcirq_pkg::ADDR_FLAGS_MAIN, 8'hFF);
        rdchk(nfcirq_pkg::ADDR_FLAGS_MAIN, 8'h00);
        // Event on a pending flag, unmapped read, housekeeping status
        pulse(5'h10, 6'h00);
        pulse(5'h10, 6'h00);
        rdchk(nfcirq_pkg::ADDR_FLAGS_MAIN, 8'h20);
        rdchk(8'h40, 8'h00);
        rdchk(nfcirq_pkg::ADDR_HK_STATUS, 8'h05);
        host.wr(nfcirq_pkg::ADDR_HK_ENABLE, 8'hFF);
        rdchk(nfcirq_pkg::ADDR_HK_ENABLE, 8'h07);
        chk(8'(irq), 8'h01);
        host.wr(nfcirq_pkg::ADDR_HK_CLEAR, 8'h07);
        rdchk(nfcirq_pkg::ADDR_HK_STATUS, 8'h00);
        chk(8'(irq), 8'h00);
        results();
    end
endmodule
`default_nettype wire
